// ==== hdl/boot_strap_flash_loader.v ====
// boot strap decoder and spi flash configuration loader
`default_nettype none
module boot_strap_flash_loader (
  input wire clk,
  input wire rst,
  input wire [6:0] address_strap_input,
  input wire [6:0] boot_strap_input,
  input wire main_supply_input,
  input wire bus_power_input,
  input wire flash_data_in,
  output reg flash_sck,
  output reg flash_cs_n,
  output reg flash_data_out,
  output reg [6:0] i2c_target_address,
  output reg [2:0] db_mode,
  output reg [2:0] default_config,
  output reg internal_switch_en,
  output reg external_switch_en,
  output reg ports_disabled,
  output reg legacy_sink,
  output reg config_loaded,
  output reg boot_done,
  output reg byte_valid,
  output reg [7:0] byte_data
);
`include "boot_strap_flash_loader_regs.vh"
  localparam ST_INIT = 4'h0; // register initialisation
  localparam ST_STRAP = 4'h1; // strap capture
  localparam ST_HOLD = 4'h2; // wait main supply
  localparam ST_CMD = 4'h3; // send read command/address
  localparam ST_DATA = 4'h4; // stream bundle bytes
  localparam ST_END = 4'h5; // check bundle
  localparam ST_RETRY = 4'h6; // gap before retry
  localparam ST_RUN = 4'h7; // boot finished
  // start address as a vector so its bytes can be sliced
  localparam [23:0] FLASH_ADDR = `FLASH_START_ADDR;

  reg [3:0] state;
  reg [3:0] next_state;
  // two-flop synchronisers for pins
  reg miso_meta;
  reg miso_sync;
  reg main_meta;
  reg main_sync;
  reg bus_meta;
  reg bus_sync;
  reg [2:0] addr_code; // decoded address strap
  reg [2:0] mode_dec; // decoded dead-battery mode
  reg [2:0] cfg_dec; // decoded configuration
  reg strap_hi; // captured data-in level
  reg [1:0] init_cnt; // synchroniser fill count after reset
  reg [2:0] cmd_idx; // command byte index
  reg [15:0] byte_cnt; // bundle bytes received
  reg bundle_ok; // first byte carried the mark
  reg start; // byte shifter start pulse
  reg [7:0] tx_byte; // byte to send
  // shifter outputs, re-registered below so pins leave flops
  wire sh_sck;
  wire sh_mosi;
  wire sh_busy;
  wire sh_done;
  wire [7:0] sh_rx;
  wire on_bus; // dead-battery condition

  // pin synchronisers, first stage only feeds second
  // reading a first stage directly could pass on a metastable level
  always @(posedge clk) begin
    if (rst) begin
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
      main_meta <= 1'b0;
      main_sync <= 1'b0;
      bus_meta <= 1'b0;
      bus_sync <= 1'b0;
    end else begin
      miso_meta <= flash_data_in;
      miso_sync <= miso_meta;
      main_meta <= main_supply_input;
      main_sync <= main_meta;
      bus_meta <= bus_power_input;
      bus_sync <= bus_meta;
    end
  end

  // dead battery only without main supply
  assign on_bus = bus_sync & ~main_sync;

  // address strap decode; gaps fall to code 000
  always @* begin
    if (address_strap_input <= `RATIO_18)
      addr_code = 3'h0;
    else if (address_strap_input >= `RATIO_20 && address_strap_input <= `RATIO_38)
      addr_code = 3'h1;
    else if (address_strap_input >= `RATIO_40 && address_strap_input <= `RATIO_58)
      addr_code = 3'h2;
    else if (address_strap_input >= `RATIO_60 && address_strap_input <= `RATIO_100)
      addr_code = 3'h3;
    else
      addr_code = 3'h0;
  end

  // boot strap decode from captured data-in level
  always @* begin
    mode_dec = `DB_HOLD_OFF;
    cfg_dec = `CFG_SAFE;
    if (strap_hi) begin
      if (boot_strap_input <= `RATIO_18) begin
        mode_dec = `DB_HOLD_OFF;
      end else if (boot_strap_input >= `RATIO_20 && boot_strap_input <= `RATIO_28) begin
        mode_dec = `DB_INTERNAL_SUPPLY_WAIT;
      end else if (boot_strap_input >= `RATIO_30 && boot_strap_input <= `RATIO_38) begin
        mode_dec = `DB_INTERNAL_RETRY;
        cfg_dec = `CFG_INFINITE_WAIT;
      end else if (boot_strap_input >= `RATIO_40 && boot_strap_input <= `RATIO_48) begin
        mode_dec = `DB_EXTERNAL_SUPPLY_WAIT;
      end else if (boot_strap_input >= `RATIO_50 && boot_strap_input <= `RATIO_58) begin
        mode_dec = `DB_EXTERNAL_RETRY;
        cfg_dec = `CFG_INFINITE_WAIT;
      end else if (boot_strap_input >= `RATIO_60 && boot_strap_input <= `RATIO_100) begin
        mode_dec = `DB_NO_WAIT;
      end
    end else begin
      // data-in low table; reserved bands fall through
      if (boot_strap_input >= `RATIO_10 && boot_strap_input <= `RATIO_18) begin
        cfg_dec = `CFG_ONE;
      end else if (boot_strap_input >= `RATIO_20 && boot_strap_input <= `RATIO_28) begin
        mode_dec = `DB_NO_WAIT;
        cfg_dec = `CFG_TWO;
      end else if (boot_strap_input >= `RATIO_30 && boot_strap_input <= `RATIO_38) begin
        mode_dec = `DB_INTERNAL_RETRY;
        cfg_dec = `CFG_INFINITE_WAIT;
      end else if (boot_strap_input >= `RATIO_40 && boot_strap_input <= `RATIO_48) begin
        mode_dec = `DB_NO_WAIT;
        cfg_dec = `CFG_THREE;
      end else if (boot_strap_input >= `RATIO_50 && boot_strap_input <= `RATIO_58) begin
        mode_dec = `DB_EXTERNAL_RETRY;
        cfg_dec = `CFG_INFINITE_WAIT;
      end else if (boot_strap_input >= `RATIO_60 && boot_strap_input <= `RATIO_68) begin
        mode_dec = `DB_NO_WAIT;
        cfg_dec = `CFG_FOUR;
      end else if (boot_strap_input >= `RATIO_90 && boot_strap_input <= `RATIO_100) begin
        mode_dec = `DB_NO_WAIT;
        cfg_dec = `CFG_FIVE;
      end
    end
  end

  // spi byte engine
  spi_byte_shifter u_shifter (
    .clk(clk),
    .rst(rst),
    .start(start),
    .tx_byte(tx_byte),
    .miso_sync(miso_sync),
    .sck(sh_sck),
    .mosi(sh_mosi),
    .busy(sh_busy),
    .done(sh_done),
    .rx_byte(sh_rx)
  );

  // command byte sequence: read opcode then 24-bit address
  // address bytes are sliced, not shifted, to keep widths exact
  always @* begin
    case (cmd_idx)
      3'h0: tx_byte = `FLASH_READ_CMD;
      3'h1: tx_byte = FLASH_ADDR[23:16];
      3'h2: tx_byte = FLASH_ADDR[15:8];
      3'h3: tx_byte = FLASH_ADDR[7:0];
      default: tx_byte = 8'h00;
    endcase
  end

  // next state
  always @* begin
    next_state = state;
    case (state)
      ST_INIT: begin
        if (init_cnt == `STRAP_SETTLE_CYC)
          next_state = ST_STRAP;
      end
      ST_STRAP: next_state = ST_HOLD;
      ST_HOLD: begin
        // stall until main supply in hold-off and supply-wait modes
        // off bus power the dead-battery modes do not apply
        if (!on_bus || main_sync)
          next_state = ST_CMD;
        else if (db_mode != `DB_HOLD_OFF && db_mode != `DB_INTERNAL_SUPPLY_WAIT &&
                 db_mode != `DB_EXTERNAL_SUPPLY_WAIT)
          next_state = ST_CMD;
      end
      ST_CMD: if (sh_done && cmd_idx == 3'h3) next_state = ST_DATA;
      ST_DATA: if (sh_done && byte_cnt == (`BUNDLE_BYTES - 16'h0001)) next_state = ST_END;
      ST_END: begin
        if (bundle_ok || default_config != `CFG_INFINITE_WAIT)
          next_state = ST_RUN;
        else
          next_state = ST_RETRY;
      end
      ST_RETRY: next_state = ST_CMD;
      ST_RUN: next_state = ST_RUN;
      default: next_state = ST_INIT;
    endcase
  end

  // boot sequencer and outputs
  // every output is a flop; shifter clock and data pass one stage
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_INIT;
      strap_hi <= 1'b0;
      flash_sck <= 1'b0;
      flash_cs_n <= 1'b1;
      flash_data_out <= 1'b0;
      i2c_target_address <= 7'h00;
      db_mode <= `DB_HOLD_OFF;
      default_config <= `CFG_SAFE;
      internal_switch_en <= 1'b0;
      external_switch_en <= 1'b0;
      ports_disabled <= 1'b1;
      legacy_sink <= 1'b0;
      config_loaded <= 1'b0;
      boot_done <= 1'b0;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      cmd_idx <= 3'h0;
      byte_cnt <= 16'h0000;
      bundle_ok <= 1'b0;
      start <= 1'b0;
      init_cnt <= 2'h0;
    end else begin
      state <= next_state;
      start <= 1'b0;
      byte_valid <= 1'b0;
      flash_sck <= sh_sck;
      // data and select in same edge
      flash_data_out <= sh_mosi;
      case (state)
        ST_INIT: begin
          // count out the two synchroniser stages after reset
          init_cnt <= init_cnt + 2'h1;
          // latch data-in level while cs high; last write wins
          strap_hi <= miso_sync;
        end
        ST_STRAP: begin
          // code into address bits 3:1
          // upper bits fixed, bit 0 left clear
          i2c_target_address <= {`I2C_ADDR_UPPER, addr_code, `I2C_ADDR_LSB};
          db_mode <= mode_dec;
          default_config <= cfg_dec;
        end
        ST_HOLD: begin
          internal_switch_en <= on_bus &&
            (db_mode == `DB_INTERNAL_SUPPLY_WAIT || db_mode == `DB_INTERNAL_RETRY);
          external_switch_en <= on_bus &&
            (db_mode == `DB_EXTERNAL_SUPPLY_WAIT || db_mode == `DB_EXTERNAL_RETRY);
          if (next_state == ST_CMD) begin
            cmd_idx <= 3'h0;
            start <= 1'b1;
          end
        end
        ST_CMD: begin
          // select active low for the frame
          // wait for the shifter so select and first bit leave together
          if (sh_busy)
            flash_cs_n <= 1'b0;
          if (sh_done) begin
            cmd_idx <= cmd_idx + 3'h1;
            byte_cnt <= 16'h0000;
            start <= 1'b1;
          end
        end
        ST_DATA: begin
          if (sh_done) begin
            byte_valid <= 1'b1;
            byte_data <= sh_rx;
            if (byte_cnt == 16'h0000)
              bundle_ok <= (sh_rx == `BUNDLE_VALID_MARK);
            byte_cnt <= byte_cnt + 16'h0001;
            if (byte_cnt != (`BUNDLE_BYTES - 16'h0001))
              start <= 1'b1;
          end
        end
        ST_END: begin
          flash_cs_n <= 1'b1;
          // a bad mark leaves this low; the retry decision reads bundle_ok
          config_loaded <= bundle_ok;
        end
        ST_RETRY: begin
          cmd_idx <= 3'h0;
          bundle_ok <= 1'b0;
          start <= 1'b1;
        end
        ST_RUN: begin
          // only reset leaves run, so boot_done holds
          boot_done <= 1'b1;
          if (db_mode == `DB_NO_WAIT && on_bus && config_loaded)
            internal_switch_en <= 1'b1;
          ports_disabled <= !config_loaded && default_config == `CFG_SAFE;
          legacy_sink <= !config_loaded && default_config == `CFG_SAFE && on_bus;
        end
        default: begin
          flash_cs_n <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== hdl/boot_strap_flash_loader_regs.vh ====
// constants for the boot strap decoder and flash loader
`ifndef BOOT_STRAP_FLASH_LOADER_REGS_VH
`define BOOT_STRAP_FLASH_LOADER_REGS_VH
// strap ratio codes: ratio * 100, 7 bits (0..100)
`define RATIO_W 7
`define RATIO_10 7'h0A
`define RATIO_18 7'h12
`define RATIO_20 7'h14
`define RATIO_28 7'h1C
`define RATIO_30 7'h1E
`define RATIO_38 7'h26
`define RATIO_40 7'h28
`define RATIO_48 7'h30
`define RATIO_50 7'h32
`define RATIO_58 7'h3A
`define RATIO_60 7'h3C
`define RATIO_68 7'h44
`define RATIO_90 7'h5A
`define RATIO_100 7'h64
// i2c target address: fixed upper bits, strap code at [3:1]
`define I2C_ADDR_UPPER 3'h2
`define I2C_ADDR_LSB 1'h0
// dead-battery mode codes
`define DB_HOLD_OFF 3'h0
`define DB_INTERNAL_SUPPLY_WAIT 3'h1
`define DB_INTERNAL_RETRY 3'h2
`define DB_EXTERNAL_SUPPLY_WAIT 3'h3
`define DB_EXTERNAL_RETRY 3'h4
`define DB_NO_WAIT 3'h5
// default configuration codes
`define CFG_SAFE 3'h0
`define CFG_INFINITE_WAIT 3'h1
`define CFG_ONE 3'h2
`define CFG_TWO 3'h3
`define CFG_THREE 3'h4
`define CFG_FOUR 3'h5
`define CFG_FIVE 3'h6
// spi timing: core 25 MHz, target sck 12 MHz; half period rounded up
`define CLK_HZ 25000000
`define SCK_HZ 12000000
`define SCK_HALF_CYC ((`CLK_HZ + 2 * `SCK_HZ - 1) / (2 * `SCK_HZ))
// init count at which init ends (three cycles) so the data-in synchroniser holds the pin level
`define STRAP_SETTLE_CYC 2'h2
// flash read command and bundle length
`define FLASH_READ_CMD 8'h03
`define FLASH_START_ADDR 24'h000000
`define BUNDLE_BYTES 16'h0010
`define BUNDLE_VALID_MARK 8'hA5
`endif

// ==== hdl/spi_byte_shifter.v ====
// one-byte spi mode 0 shifter: shift out on falling, sample on rising
`default_nettype none
module spi_byte_shifter (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [7:0] tx_byte,
  input wire miso_sync,
  output reg sck,
  output reg mosi,
  output reg busy,
  output reg done,
  output reg [7:0] rx_byte
);
`include "boot_strap_flash_loader_regs.vh"
  reg [3:0] bit_cnt; // bits remaining
  reg [7:0] tx_sh; // outgoing shift register
  reg [3:0] div_cnt; // half period counter

  // byte engine; first bit is on mosi as soon as start is taken
  always @(posedge clk) begin
    if (rst) begin
      sck <= 1'b0;
      mosi <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rx_byte <= 8'h00;
      bit_cnt <= 4'h0;
      tx_sh <= 8'h00;
      div_cnt <= 4'h0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        sck <= 1'b0;
        if (start) begin
          busy <= 1'b1;
          mosi <= tx_byte[7];
          tx_sh <= {tx_byte[6:0], 1'b0};
          bit_cnt <= 4'h8;
          div_cnt <= 4'h0;
        end
      end else if (div_cnt != (`SCK_HALF_CYC - 1)) begin
        div_cnt <= div_cnt + 4'h1;
      end else begin
        div_cnt <= 4'h0;
        if (!sck) begin
          // rising edge, data still on its way in
          sck <= 1'b1;
        end else begin
          sck <= 1'b0;
          // bit present at the rising edge, read late
          // the pin clock leaves one flop later and the sync adds two
          rx_byte <= {rx_byte[6:0], miso_sync};
          if (bit_cnt == 4'h1) begin
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            mosi <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
          end
          bit_cnt <= bit_cnt - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/flash_model.sv ====
// behavioural serial flash answering mode 0 reads, and the data-in strap
`default_nettype none
module flash_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic strap,
  input wire logic valid,
  output logic miso,
  output logic [31:0] cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  int bits = 0; // rising edges in this frame
  int idx = 0; // next byte to send
  logic [7:0] sh = 8'h00; // outgoing byte
  logic drv = 1'b0; // level while selected
  // low selects; deselected the strap resistor sets the level
  assign miso = cs_n ? strap : drv;
  // a new frame restarts the counters
  always @(negedge cs_n) begin
    bits = 0;
    idx = 0;
  end
  always @(posedge sck) begin
    if (!cs_n) begin
      if (bits < 32) cmd = {cmd[30:0], mosi};
      bits = bits + 1;
    end
  end
  // shift on falling; in the command phase the line is not ours, so it toggles
  always @(negedge sck) begin
    if (!cs_n && bits >= 32) begin
      if ((bits - 32) % 8 == 0) begin
        sh = (idx == 0) ? (valid ? 8'hA5 : 8'h5A) : 8'(idx * 17);
        idx = idx + 1;
      end
      drv = sh[7];
      sh = {sh[6:0], 1'b0};
    end else begin
      drv = ~drv;
    end
  end
endmodule
`default_nettype wire

// ==== tb/boot_strap_flash_loader_checker.sv ====
// timing and decode checks on the loader ports
`default_nettype none
`include "boot_strap_flash_loader_regs.vh"
module boot_strap_flash_loader_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [6:0] address_strap_input,
  input wire logic flash_sck,
  input wire logic flash_cs_n,
  input wire logic flash_data_out,
  input wire logic [6:0] i2c_target_address,
  input wire logic [2:0] db_mode,
  input wire logic [2:0] default_config,
  input wire logic internal_switch_en,
  input wire logic external_switch_en,
  input wire logic config_loaded,
  input wire logic boot_done,
  input wire logic byte_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // address code from ratio; gaps fall to zero
  function automatic logic [2:0] acode(input logic [6:0] r);
    if (r <= `RATIO_18) return 3'h0;
    if (r >= `RATIO_20 && r <= `RATIO_38) return 3'h1;
    if (r >= `RATIO_40 && r <= `RATIO_58) return 3'h2;
    if (r >= `RATIO_60) return 3'h3;
    return 3'h0;
  endfunction
  sck_idle_a: assert property (flash_cs_n |-> !flash_sck) else $error("clock not low while idle");
  sck_high_a: assert property ($rose(flash_sck) |=> flash_sck ##1 !flash_sck) else $error("high phase wrong");
  sck_low_a: assert property ($fell(flash_sck) |=> !flash_sck) else $error("low phase too short");
  data_hold_a: assert property ($rose(flash_sck) && !flash_cs_n |-> $stable(flash_data_out) ##1 $stable(flash_data_out))
    else $error("data moved near rising edge");
  frame_start_a: assert property ($fell(flash_cs_n) |-> !flash_data_out && !flash_sck ##1 !flash_sck ##1 flash_sck)
    else $error("frame start wrong");
  addr_map_a: assert property (boot_done |-> i2c_target_address == {`I2C_ADDR_UPPER, acode(address_strap_input), 1'h0})
    else $error("address bits wrong");
  hold_off_a: assert property (db_mode == `DB_HOLD_OFF |-> !internal_switch_en && !external_switch_en)
    else $error("switch on in hold-off");
  no_wait_a: assert property (db_mode == `DB_NO_WAIT && internal_switch_en |-> config_loaded)
    else $error("switch before load");
  inf_wait_a: assert property (default_config == `CFG_INFINITE_WAIT && !config_loaded |-> !boot_done)
    else $error("left boot without data");
  byte_pulse_a: assert property (byte_valid |=> !byte_valid) else $error("byte strobe too long");
  cover property (byte_valid);
  cover property (config_loaded && boot_done);
  cover property (db_mode == `DB_INTERNAL_RETRY && internal_switch_en);
endmodule
bind boot_strap_flash_loader boot_strap_flash_loader_checker chk_i (.clk(clk), .rst(rst),
  .address_strap_input(address_strap_input), .flash_sck(flash_sck), .flash_cs_n(flash_cs_n),
  .flash_data_out(flash_data_out), .i2c_target_address(i2c_target_address), .db_mode(db_mode),
  .default_config(default_config), .internal_switch_en(internal_switch_en),
  .external_switch_en(external_switch_en), .config_loaded(config_loaded), .boot_done(boot_done),
  .byte_valid(byte_valid));
`default_nettype wire

// ==== tb/testbench.sv ====
// boot strap decode and flash load scenarios
`default_nettype none
`include "boot_strap_flash_loader_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1; // core clock and reset
  logic [6:0] a_in = 7'h00, b_in = 7'h00; // strap ratios
  logic main_in = 1'b1, bus_in = 1'b0, strap = 1'b1, valid = 1'b1; // supplies, strap level, bundle good
  wire logic miso, sck, cs_n, mosi; // flash pins
  logic [31:0] cmd; // command word seen by flash
  wire logic [6:0] i2c;
  wire logic [2:0] mode, cfg;
  wire logic int_en, ext_en, ports_off, legacy, loaded, done, bv;
  wire logic [7:0] bd;
  int fails = 0, n_compared = 0, frames = 0, idx = 0;
  // rows: strap level, ratio, mode, config
  logic [13:0] tab [18] = '{
    {1'h1, 7'h12, 3'h0, 3'h0}, {1'h1, 7'h14, 3'h1, 3'h0}, {1'h1, 7'h26, 3'h2, 3'h1}, {1'h1, 7'h28, 3'h3, 3'h0},
    {1'h1, 7'h3A, 3'h4, 3'h1}, {1'h1, 7'h64, 3'h5, 3'h0}, {1'h0, 7'h0A, 3'h0, 3'h2}, {1'h0, 7'h1C, 3'h5, 3'h3},
    {1'h0, 7'h1E, 3'h2, 3'h1}, {1'h0, 7'h30, 3'h5, 3'h4}, {1'h0, 7'h32, 3'h4, 3'h1}, {1'h0, 7'h44, 3'h5, 3'h5},
    {1'h0, 7'h46, 3'h0, 3'h0}, {1'h0, 7'h58, 3'h0, 3'h0}, {1'h0, 7'h5A, 3'h5, 3'h6}, {1'h1, 7'h13, 3'h0, 3'h0},
    {1'h0, 7'h05, 3'h0, 3'h0}, {1'h0, 7'h1D, 3'h0, 3'h0}};
  // address ratio with its code
  logic [9:0] atab [9] = '{{7'h00, 3'h0}, {7'h12, 3'h0}, {7'h14, 3'h1}, {7'h26, 3'h1}, {7'h28, 3'h2},
    {7'h3A, 3'h2}, {7'h3C, 3'h3}, {7'h64, 3'h3}, {7'h13, 3'h0}};
  always #20 clk = ~clk;
  flash_model flash (.sck(sck), .cs_n(cs_n), .mosi(mosi), .strap(strap), .valid(valid), .miso(miso), .cmd(cmd));
  boot_strap_flash_loader dut (.clk(clk), .rst(rst), .address_strap_input(a_in), .boot_strap_input(b_in),
    .main_supply_input(main_in), .bus_power_input(bus_in), .flash_data_in(miso), .flash_sck(sck),
    .flash_cs_n(cs_n), .flash_data_out(mosi), .i2c_target_address(i2c), .db_mode(mode), .default_config(cfg),
    .internal_switch_en(int_en), .external_switch_en(ext_en), .ports_disabled(ports_off), .legacy_sink(legacy),
    .config_loaded(loaded), .boot_done(done), .byte_valid(bv), .byte_data(bd));
  // shared compare
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // frame count; byte index restarts per frame
  always @(negedge cs_n) begin
    frames++;
    idx = 0;
  end
  // every delivered byte matches the flash contents, MSB first
  always @(posedge clk) begin
    if (!rst && bv === 1'b1) begin
      chk("byte", (idx == 0) ? (valid ? 8'hA5 : 8'h5A) : 8'(idx * 17), bd);
      idx++;
    end
  end
  // reset with new straps and supplies, idle pins checked during reset
  task boot(input logic [6:0] a, input logic [6:0] b, input logic s, input logic m, input logic bp, input logic v);
    @(negedge clk);
    rst = 1'b1;
    {a_in, b_in, strap, main_in, bus_in, valid} = {a, b, s, m, bp, v};
    repeat (20) @(negedge clk);
    chk("idle cs", 8'h01, {7'h00, cs_n});
    chk("idle sck", 8'h00, {7'h00, sck});
    rst = 1'b0;
  endtask
  task wait_done(input int lim);
    for (int i = 0; i < lim && done !== 1'b1; i++) @(negedge clk);
  endtask
  // whole strap table plus gaps, address codes alongside
  task t_straps;
    for (int i = 0; i < 18; i++) begin
      boot(atab[i % 9][9:3], tab[i][12:6], tab[i][13], 1'b1, 1'b0, 1'b1);
      wait_done(4000);
      chk("done", 8'h01, {7'h00, done});
      chk("mode", {5'h00, tab[i][5:3]}, {5'h00, mode});
      chk("config", {5'h00, tab[i][2:0]}, {5'h00, cfg});
      chk("addr", {1'h0, `I2C_ADDR_UPPER, atab[i % 9][2:0], 1'h0}, {1'h0, i2c});
      chk("cmd", `FLASH_READ_CMD, cmd[31:24]);
      chk("addr sent", 8'h00, cmd[23:16] | cmd[15:8] | cmd[7:0]);
      chk("loaded", 8'h01, {7'h00, loaded});
    end
    $display("test straps done");
  endtask
  // bus powered, main absent: stall without a frame until main appears
  task t_stall(input logic [6:0] b, input logic ei, input logic ee);
    int f0;
    boot(7'h00, b, 1'b1, 1'b0, 1'b1, 1'b1);
    f0 = frames;
    repeat (1500) @(negedge clk);
    chk("stall frames", 8'h00, 8'(frames - f0));
    chk("int switch", {7'h00, ei}, {7'h00, int_en});
    chk("ext switch", {7'h00, ee}, {7'h00, ext_en});
    chk("stalled", 8'h00, {7'h00, done});
    main_in = 1'b1;
    wait_done(5000);
    chk("resumed", 8'h01, {7'h00, done});
    $display("test stall %h done", b);
  endtask
  // retry modes keep loading a bad bundle until a good one appears
  task t_retry(input logic [6:0] b, input logic ei, input logic ee);
    int f0;
    boot(7'h00, b, 1'b1, 1'b0, 1'b1, 1'b0);
    f0 = frames;
    for (int i = 0; i < 20000 && frames < f0 + 3; i++) @(negedge clk);
    chk("retries", 8'h01, {7'h00, frames >= f0 + 3});
    chk("int switch", {7'h00, ei}, {7'h00, int_en});
    chk("ext switch", {7'h00, ee}, {7'h00, ext_en});
    chk("in boot", 8'h00, {7'h00, done});
    @(posedge cs_n);
    valid = 1'b1;
    wait_done(8000);
    chk("loaded", 8'h01, {7'h00, loaded});
    $display("test retry %h done", b);
  endtask
  // safe without data, then no-wait with data, both on bus power
  task t_safe;
    boot(7'h00, 7'h64, 1'b1, 1'b0, 1'b1, 1'b0);
    wait_done(8000);
    chk("done", 8'h01, {7'h00, done});
    chk("loaded", 8'h00, {7'h00, loaded});
    chk("ports off", 8'h01, {7'h00, ports_off});
    chk("legacy", 8'h01, {7'h00, legacy});
    boot(7'h00, 7'h64, 1'b1, 1'b0, 1'b1, 1'b1);
    wait_done(8000);
    chk("switch after load", 8'h01, {7'h00, int_en & loaded});
    $display("test safe done");
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    t_straps();
    t_stall(7'h00, 1'b0, 1'b0);
    t_stall(7'h19, 1'b1, 1'b0);
    t_stall(7'h2A, 1'b0, 1'b1);
    t_retry(7'h23, 1'b1, 1'b0);
    t_retry(7'h37, 1'b0, 1'b1);
    t_safe();
    give_verdict();
  end
  // watchdog: about 30k cycles expected, give up at 75k
  initial begin
    #3000000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
